// ---- common/uorx_consts.svh ----
// register offsets, field positions and reset values of the receive endpoint block
// assumes byte addresses on the register port, one aligned 32-bit word per register
`ifndef UORX_CONSTS_SVH
`define UORX_CONSTS_SVH
`define UORX_OFS_CMD      8'h00
`define UORX_OFS_MODE     8'h04
`define UORX_OFS_PORT     8'h08
`define UORX_OFS_ASYNC    8'h0C
`define UORX_OFS_EP_BASE  8'h40
`define UORX_CMD_RUN      0
`define UORX_CMD_RST      1
`define UORX_CMD_PSE      4
`define UORX_CMD_ASE      5
`define UORX_MODE_HOST    0
`define UORX_MODE_ES      2
`define UORX_MODE_STREAM_DISABLE_BIT    4
`define UORX_PORT_PP      12
`define UORX_PORT_PTS     30
`define UORX_EP_ENA       7
`define UORX_EP_TRST      6
`define UORX_EP_TINH      5
`define UORX_EP_TYPE_HI   3
`define UORX_EP_TYPE_LO   2
`define UORX_EP_SINK      1
`define UORX_EP_STALL     0
`define UORX_RST_WORD     32'h0000_0000
`define UORX_CMD_MASK     32'h0000_0033
`define UORX_MODE_MASK    32'h0000_0015
`define UORX_PORT_MASK    32'h4000_1000
`define UORX_ASYNC_MASK   32'hFFFF_FFE0
`endif

// ---- common/uorx_pkg.sv ----
// types shared by the receive endpoint block and its bench
// assumes uorx_consts.svh is included by the design file
package uorx_pkg;
	// transfer type held in the endpoint type field
	typedef enum logic [1:0] {
		UORX_CONTROL = 2'b00,
		UORX_ISO     = 2'b01,
		UORX_BULK    = 2'b10,
		UORX_INTR    = 2'b11
	} uorx_type_t;
	// handshake answered to the far side
	typedef enum logic [1:0] {
		UORX_HS_NONE  = 2'b00,
		UORX_HS_ACK   = 2'b01,
		UORX_HS_NAK   = 2'b10,
		UORX_HS_STALL = 2'b11
	} uorx_hs_t;
endpackage

// ---- src/uorx_top.sv ----
// receive endpoint control, mode registers and the shared receive buffer
// assumes packet and dma strobes come from logic on clk_sys, so no synchronisers
//
// What this block does
// - endpoint enable bit seven gates reception of all but SETUP packets
// - toggle reset write resynchronises data PID
// - toggle inhibit accepts every data packet
// - type field: control, iso, bulk, interrupt
// - SETUP stalls every non-control endpoint
// - SETUP unstalls control type endpoints
// - stall bit answers STALL until cleared
// - dma moves all data to memory
// - host mode uses host queue structures
// - device mode queues per active pipe
// - one shared channel, host and device alike
// - sixteen-byte receive buffer shared
// - reset selects on-chip full-speed transceiver
// - only listed phy and mode combinations
// - controller reset restores register defaults
// - schedules may run before port enabled
`timescale 1ns/1ns
`include "uorx_consts.svh"

// small fifo, width and depth set its structure
module uorx_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 4
) (
	input  wire logic             clk_sys,
	input  wire logic             nrst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wp_r;
	logic [AW-1:0]    wp_nxt;
	logic [AW-1:0]    rp_r;
	logic [AW-1:0]    rp_nxt;
	logic [AW:0]      cnt_r;
	logic [AW:0]      cnt_nxt;
	logic             push;
	logic             pop;

	// honest full and empty from the count
	assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
	assign out_valid = (cnt_r != '0);
	assign out_data  = mem_r[rp_r];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// pointer and count next values
	always_comb begin
		wp_nxt  = wp_r;
		rp_nxt  = rp_r;
		cnt_nxt = cnt_r;
		if (push) begin
			wp_nxt = (wp_r == AW'(DEPTH-1)) ? '0 : AW'(wp_r + 1'b1);
		end
		if (pop) begin
			rp_nxt = (rp_r == AW'(DEPTH-1)) ? '0 : AW'(rp_r + 1'b1);
		end
		if (push & ~pop) begin
			cnt_nxt = (AW+1)'(cnt_r + 1'b1);
		end else if (pop & ~push) begin
			cnt_nxt = (AW+1)'(cnt_r - 1'b1);
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			wp_r  <= wp_nxt;
			rp_r  <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// storage needs no reset, only written words are read
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem_r[wp_r] <= in_data;
		end
	end
endmodule

module uorx_top
	import uorx_pkg::*;
#(
	parameter int NEP   = 4,
	parameter int EPW   = 2,
	parameter int DEPTH = 4
) (
	input  wire logic            clk_sys,
	input  wire logic            nrst,
	input  wire logic            reg_cs,
	input  wire logic            reg_we,
	input  wire logic [7:0]      reg_addr,
	input  wire logic [31:0]     reg_wdata,
	output logic      [31:0]     reg_rdata,
	output logic                 reg_ack,
	input  wire logic            pkt_valid,
	input  wire logic            pkt_setup,
	input  wire logic [EPW-1:0]  pkt_ep,
	input  wire logic            pkt_pid1,
	input  wire logic [31:0]     pkt_data,
	output logic                 pkt_ready,
	output logic                 hs_valid,
	output uorx_pkg::uorx_hs_t   hs_code,
	output logic                 dma_valid,
	input  wire logic            dma_ready,
	output logic      [31:0]     dma_data,
	output logic      [EPW-1:0]  dma_ep,
	output logic                 mode_host,
	output logic                 phy_ulpi,
	output logic                 fs_only,
	output logic                 big_endian,
	output logic                 stream_off,
	output logic                 port_power,
	output logic                 async_run,
	output logic                 periodic_run,
	output logic      [31:0]     async_base
);
	import uorx_pkg::*;

	logic [31:0]    cmd_r, cmd_nxt;
	logic [31:0]    mode_r, mode_nxt;
	logic [31:0]    port_r, port_nxt;
	logic [31:0]    async_r, async_nxt;
	logic [NEP-1:0] ena_r, ena_nxt;
	logic [NEP-1:0] inh_r, inh_nxt;
	logic [NEP-1:0] stall_r, stall_nxt;
	logic [NEP-1:0] tog_r, tog_nxt;
	logic [1:0]     type_r [NEP];
	logic [1:0]     type_nxt [NEP];
	logic [31:0]    rdata_nxt;
	logic           hs_v_nxt;
	uorx_hs_t       hs_nxt;
	logic           wr;
	logic           ctl_rst;
	logic           push;
	logic           fifo_in_ready;
	logic [EPW-1:0] ep_idx;
	logic           ep_hit;

	assign wr      = reg_cs & reg_we;
	assign ctl_rst = cmd_r[`UORX_CMD_RST];
	assign ep_idx  = EPW'(reg_addr[7:2] - 6'(`UORX_OFS_EP_BASE >> 2));
	assign ep_hit  = (reg_addr >= `UORX_OFS_EP_BASE)
		&& (reg_addr < 8'(`UORX_OFS_EP_BASE + 4*NEP)) && (reg_addr[1:0] == 2'b00);

	// controller registers; reset bit wipes all but the receive buffer one cycle later
	always_comb begin
		cmd_nxt   = cmd_r;
		mode_nxt  = mode_r;
		port_nxt  = port_r;
		async_nxt = async_r;
		if (ctl_rst) begin
			cmd_nxt   = `UORX_RST_WORD;
			mode_nxt  = `UORX_RST_WORD;
			port_nxt  = `UORX_RST_WORD;
			async_nxt = `UORX_RST_WORD;
		end else if (wr) begin
			case (reg_addr)
				`UORX_OFS_CMD:   cmd_nxt   = reg_wdata & `UORX_CMD_MASK;
				`UORX_OFS_MODE:  mode_nxt  = reg_wdata & `UORX_MODE_MASK;
				`UORX_OFS_PORT:  port_nxt  = reg_wdata & `UORX_PORT_MASK;
				`UORX_OFS_ASYNC: async_nxt = reg_wdata & `UORX_ASYNC_MASK;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cmd_r   <= `UORX_RST_WORD;
			mode_r  <= `UORX_RST_WORD;
			port_r  <= `UORX_RST_WORD;
			async_r <= `UORX_RST_WORD;
		end else begin
			cmd_r   <= cmd_nxt;
			mode_r  <= mode_nxt;
			port_r  <= port_nxt;
			async_r <= async_nxt;
		end
	end

	// mode outputs; on-chip transceiver cannot do high speed
	assign mode_host    = mode_r[`UORX_MODE_HOST];
	assign big_endian   = mode_r[`UORX_MODE_ES];
	assign stream_off   = mode_r[`UORX_MODE_STREAM_DISABLE_BIT];
	assign port_power   = port_r[`UORX_PORT_PP];
	assign phy_ulpi     = port_r[`UORX_PORT_PTS];
	assign fs_only      = ~phy_ulpi;
	assign async_base   = async_r;
	// no port-enable term, schedules may start on an idle port
	assign async_run    = cmd_r[`UORX_CMD_RUN] & cmd_r[`UORX_CMD_ASE];
	assign periodic_run = cmd_r[`UORX_CMD_RUN] & cmd_r[`UORX_CMD_PSE];

	// endpoint state: software write first, packet effects after so hardware sets win
	always_comb begin
		ena_nxt   = ena_r;
		inh_nxt   = inh_r;
		stall_nxt = stall_r;
		tog_nxt   = tog_r;
		type_nxt  = type_r;
		hs_v_nxt  = 1'b0;
		hs_nxt    = UORX_HS_NONE;
		push      = 1'b0;
		if (ctl_rst) begin
			ena_nxt   = NEP'(1);
			inh_nxt   = '0;
			stall_nxt = '0;
			tog_nxt   = '0;
			for (int i = 0; i < NEP; i++) begin
				type_nxt[i] = UORX_CONTROL;
			end
		end else begin
			if (wr && ep_hit) begin
				ena_nxt[ep_idx]   = reg_wdata[`UORX_EP_ENA];
				inh_nxt[ep_idx]   = reg_wdata[`UORX_EP_TINH];
				stall_nxt[ep_idx] = reg_wdata[`UORX_EP_STALL];
				type_nxt[ep_idx]  = reg_wdata[`UORX_EP_TYPE_HI:`UORX_EP_TYPE_LO];
				if (reg_wdata[`UORX_EP_TRST]) begin
					tog_nxt[ep_idx]  = 1'b0;
				end
			end
			// endpoint zero is a control endpoint, always enabled
			ena_nxt[0]  = 1'b1;
			type_nxt[0] = UORX_CONTROL;
			if (pkt_valid && pkt_setup) begin
				for (int i = 0; i < NEP; i++) begin
					stall_nxt[i] = (type_nxt[i] != UORX_CONTROL);
				end
				tog_nxt[pkt_ep] = 1'b1; // data stage after SETUP starts at DATA1
				push     = fifo_in_ready;
				hs_v_nxt = fifo_in_ready;
				hs_nxt   = fifo_in_ready ? UORX_HS_ACK : UORX_HS_NONE;
			end else if (pkt_valid && ena_r[pkt_ep]) begin
				hs_v_nxt = 1'b1;
				if (stall_r[pkt_ep]) begin
					hs_nxt = UORX_HS_STALL;
				end else if (!fifo_in_ready) begin
					hs_nxt = UORX_HS_NAK;
				end else begin
					hs_nxt = UORX_HS_ACK;
					// duplicate packet is acked but its data is dropped
					if (inh_r[pkt_ep] || (pkt_pid1 == tog_r[pkt_ep])) begin
						push            = 1'b1;
						tog_nxt[pkt_ep] = ~tog_r[pkt_ep];
					end
				end
			end
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			ena_r    <= NEP'(1);
			inh_r    <= '0;
			stall_r  <= '0;
			tog_r    <= '0;
			hs_valid <= 1'b0;
			hs_code  <= UORX_HS_NONE;
			for (int i = 0; i < NEP; i++) begin
				type_r[i] <= UORX_CONTROL;
			end
		end else begin
			ena_r    <= ena_nxt;
			inh_r    <= inh_nxt;
			stall_r  <= stall_nxt;
			tog_r    <= tog_nxt;
			hs_valid <= hs_v_nxt;
			hs_code  <= hs_nxt;
			type_r   <= type_nxt;
		end
	end

	// read mux; unmapped addresses read zero, sink bit always reads zero
	always_comb begin
		rdata_nxt = `UORX_RST_WORD;
		case (reg_addr)
			`UORX_OFS_CMD:   rdata_nxt = cmd_r;
			`UORX_OFS_MODE:  rdata_nxt = mode_r;
			`UORX_OFS_PORT:  rdata_nxt = port_r;
			`UORX_OFS_ASYNC: rdata_nxt = async_r;
			default: begin
				if (ep_hit) begin
					rdata_nxt[`UORX_EP_ENA]   = ena_r[ep_idx];
					rdata_nxt[`UORX_EP_TRST]  = 1'b0;
					rdata_nxt[`UORX_EP_TINH]  = inh_r[ep_idx];
					rdata_nxt[`UORX_EP_TYPE_HI:`UORX_EP_TYPE_LO] = type_r[ep_idx];
					rdata_nxt[`UORX_EP_SINK]  = 1'b0;
					rdata_nxt[`UORX_EP_STALL] = stall_r[ep_idx];
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= `UORX_RST_WORD;
			reg_ack   <= 1'b0;
		end else begin
			reg_rdata <= (reg_cs & ~reg_we) ? rdata_nxt : reg_rdata;
			reg_ack   <= reg_cs;
		end
	end

	// one shared 16-byte receive channel, tagged with the endpoint for the dma side
	assign pkt_ready = fifo_in_ready;
	uorx_fifo #(
		.WIDTH (32 + EPW),
		.DEPTH (DEPTH)
	) u_rx_buf (
		.clk_sys   (clk_sys),
		.nrst      (nrst),
		.in_valid  (push),
		.in_ready  (fifo_in_ready),
		.in_data   ({pkt_ep, pkt_data}),
		.out_valid (dma_valid),
		.out_ready (dma_ready),
		.out_data  ({dma_ep, dma_data})
	);
	// queue parsing sits in the dma master; mode_host picks its structure set
endmodule

// ---- test/uorx_chk_sva.sv ----
// port assertions for the receive endpoint block
// assumes uorx_top on one clock, clk_sys, with active-low nrst
`timescale 1ns/1ns
`include "uorx_consts.svh"
module uorx_chk
	import uorx_pkg::*;
#(
	parameter int EPW = 2
) (
	input wire logic             clk_sys,
	input wire logic             nrst,
	input wire logic             reg_cs,
	input wire logic             reg_we,
	input wire logic [7:0]       reg_addr,
	input wire logic [31:0]      reg_wdata,
	input wire logic [31:0]      reg_rdata,
	input wire logic             reg_ack,
	input wire logic             pkt_valid,
	input wire logic             pkt_setup,
	input wire logic             pkt_ready,
	input wire logic             hs_valid,
	input wire uorx_pkg::uorx_hs_t hs_code,
	input wire logic             dma_valid,
	input wire logic             dma_ready,
	input wire logic [31:0]      dma_data,
	input wire logic [EPW-1:0]   dma_ep,
	input wire logic             mode_host,
	input wire logic             phy_ulpi,
	input wire logic             fs_only,
	input wire logic             port_power,
	input wire logic             async_run,
	input wire logic             periodic_run,
	input wire logic [31:0]      async_base
);
	import uorx_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	// decoded command writes
	wire logic cmd_wr = reg_cs && reg_we && reg_addr == `UORX_OFS_CMD;
	a_ep_read_clean: assert property (reg_cs && !reg_we && reg_addr >= `UORX_OFS_EP_BASE |=>
		reg_ack && !reg_rdata[`UORX_EP_TRST] && !reg_rdata[`UORX_EP_SINK])
		else $error("endpoint read shows a write-only bit");
	a_hs_needs_pkt: assert property (!pkt_valid |=> !hs_valid)
		else $error("handshake without a packet");
	a_full_no_ack: assert property (pkt_valid && !pkt_setup && !pkt_ready |=>
		!hs_valid || hs_code != UORX_HS_ACK) else $error("ack with buffer full");
	a_dma_hold: assert property (dma_valid && !dma_ready |=>
		dma_valid && $stable(dma_data) && $stable(dma_ep)) else $error("head word moved");
	a_pop_frees: assert property (dma_valid && dma_ready |=> pkt_ready)
		else $error("no room after a pop");
	a_fs_vs_phy: assert property (fs_only == !phy_ulpi)
		else $error("speed limit does not follow phy");
	a_ctrl_reset: assert property (cmd_wr && reg_wdata[`UORX_CMD_RST] |-> ##2
		!mode_host && !port_power && !phy_ulpi && async_base == 32'h0)
		else $error("controller reset left state");
	a_stop_halts: assert property (cmd_wr && !reg_wdata[`UORX_CMD_RUN] |=>
		!async_run && !periodic_run) else $error("schedule runs while stopped");
	a_async_load: assert property (reg_cs && reg_we && reg_addr == `UORX_OFS_ASYNC |=>
		async_base == ($past(reg_wdata) & `UORX_ASYNC_MASK)) else $error("async base wrong");
endmodule
bind uorx_top uorx_chk #(.EPW(EPW)) chk_i (.clk_sys, .nrst, .reg_cs, .reg_we, .reg_addr,
	.reg_wdata, .reg_rdata, .reg_ack, .pkt_valid, .pkt_setup, .pkt_ready, .hs_valid,
	.hs_code, .dma_valid, .dma_ready, .dma_data, .dma_ep, .mode_host, .phy_ulpi, .fs_only,
	.port_power, .async_run, .periodic_run, .async_base);

// ---- test/uorx_host.sv ----
// far-side model: sends one packet per call and returns the handshake
// assumes the block samples packets on rising clk_sys
`timescale 1ns/1ns
module uorx_host
	import uorx_pkg::*;
(
	input  wire logic               clk_sys,
	input  wire logic               hs_valid,
	input  wire uorx_pkg::uorx_hs_t hs_code,
	output logic                    pkt_valid,
	output logic                    pkt_setup,
	output logic [1:0]              pkt_ep,
	output logic                    pkt_pid1,
	output logic [31:0]             pkt_data
);
	import uorx_pkg::*;
	// idle lines at time zero
	initial begin
		{pkt_valid, pkt_setup, pkt_ep, pkt_pid1} = 5'h00;
		pkt_data = 32'h0;
	end
	// held over its edge; released data is inverted so stale words never look valid
	task automatic send(input logic s, input logic [1:0] e, input logic p,
		input logic [31:0] d, output uorx_hs_t h);
		@(posedge clk_sys);
		#2;
		{pkt_valid, pkt_setup, pkt_ep, pkt_pid1, pkt_data} = {1'b1, s, e, p, d};
		@(posedge clk_sys);
		#2;
		pkt_valid = 1'b0;
		pkt_data = ~d;
		h = hs_valid ? hs_code : UORX_HS_NONE;
	endtask
endmodule

// ---- test/tb_top.sv ----
// self-checking bench: registers, packets, setup stalls, buffer and host bring-up
// assumes uorx_top with default parameters and the host model uorx_host
`timescale 1ns/1ns
module tb_top;
	import uorx_pkg::*;
	logic        clk_sys = 1'b0, nrst = 1'b0, reg_cs = 1'b0, reg_we = 1'b0;
	logic        dma_ready = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0, rnd = 32'h0001_0172, q, w;
	logic        pkt_valid, pkt_setup, pkt_pid1, pkt_ready, hs_valid, reg_ack, dma_valid;
	logic        mode_host, phy_ulpi, fs_only, big_endian, stream_off, port_power;
	logic        async_run, periodic_run;
	logic [1:0]  pkt_ep, dma_ep;
	logic [31:0] pkt_data, reg_rdata, dma_data, async_base;
	logic [33:0] expq[$];
	uorx_hs_t    hs_code, h;
	int          err_total = 0, n_compared = 0;
	logic [7:0]  zero_a[8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h44, 8'h48, 8'h4C, 8'h80};
	// free-running system clock
	always #20 clk_sys = ~clk_sys;
	uorx_top dut (.clk_sys, .nrst, .reg_cs, .reg_we, .reg_addr, .reg_wdata, .reg_rdata,
		.reg_ack, .pkt_valid, .pkt_setup, .pkt_ep, .pkt_pid1, .pkt_data, .pkt_ready,
		.hs_valid, .hs_code, .dma_valid, .dma_ready, .dma_data, .dma_ep, .mode_host,
		.phy_ulpi, .fs_only, .big_endian, .stream_off, .port_power, .async_run,
		.periodic_run, .async_base);
	uorx_host host (.clk_sys, .hs_valid, .hs_code, .pkt_valid, .pkt_setup, .pkt_ep,
		.pkt_pid1, .pkt_data);
	function automatic logic [31:0] nxt(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	// readback keeps enable, inhibit, type and stall; reset and sink read zero
	function automatic logic [31:0] ep_view(input logic [31:0] v);
		return v & 32'h0000_00AD;
	endfunction
	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic rw(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		#2;
		{reg_cs, reg_we, reg_addr, reg_wdata} = {1'b1, we, a, d};
		@(posedge clk_sys);
		#2;
		reg_cs = 1'b0;
		reg_wdata = ~d;
		q = reg_rdata;
		chk("reg_ack", reg_ack, 1'b1);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		rw(1'b0, a, 32'h0);
		chk("reg_rdata", q, e);
	endtask
	// pushed words are queued with their endpoint for the drain
	task automatic pk(input logic s, input logic [1:0] e, input logic p, input uorx_hs_t x,
		input logic push);
		rnd = nxt(rnd);
		host.send(s, e, p, rnd, h);
		chk("hs_code", h, x);
		if (push) expq.push_back({e, rnd});
	endtask
	// memory side stalls at random while words are popped
	task automatic drain();
		repeat (40) begin
			@(posedge clk_sys);
			#2;
			rnd = nxt(rnd);
			dma_ready = dma_valid && rnd[0];
			if (dma_ready) chk("dma_word", {dma_ep, dma_data}, expq.pop_front());
		end
		// let the last accepted pop happen before ready drops
		@(posedge clk_sys);
		#2;
		dma_ready = 1'b0;
		chk("dma_left", {dma_valid, expq.size()}, 0);
	endtask
	task automatic complete_run();
		$display("compared %0d mismatched %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// hang guard, far above the expected run length
	initial begin
		#100000;
		err_total++;
		complete_run();
	end
	// main sequence
	initial begin
		repeat (4) @(posedge clk_sys);
		#2;
		nrst = 1'b1;
		rchk(8'h40, 32'h80);
		foreach (zero_a[i]) rchk(zero_a[i], 32'h0);
		chk("phy", {phy_ulpi, fs_only}, 2'b01);
		$display("test reset values done");
		for (int t = 0; t < 4; t++) begin
			rnd = nxt(rnd);
			// reserved and sink bits stay zero as software must write them
			w = {24'h0, rnd[7:5], 1'b0, t[1:0], 1'b0, rnd[0]};
			rw(1'b1, 8'h44, w);
			rchk(8'h44, ep_view(w));
		end
		$display("test endpoint fields done");
		rw(1'b1, 8'h44, 32'hC8);
		pk(1'b0, 2'd1, 1'b0, UORX_HS_ACK, 1'b1);
		pk(1'b0, 2'd1, 1'b1, UORX_HS_ACK, 1'b1);
		pk(1'b0, 2'd1, 1'b1, UORX_HS_ACK, 1'b0);
		pk(1'b0, 2'd2, 1'b0, UORX_HS_NONE, 1'b0);
		drain();
		rw(1'b1, 8'h44, 32'hA8);
		pk(1'b0, 2'd1, 1'b1, UORX_HS_ACK, 1'b1);
		pk(1'b0, 2'd1, 1'b1, UORX_HS_ACK, 1'b1);
		rw(1'b1, 8'h44, 32'h89);
		pk(1'b0, 2'd1, 1'b0, UORX_HS_STALL, 1'b0);
		drain();
		$display("test packets done");
		rw(1'b1, 8'h44, 32'h88);
		rw(1'b1, 8'h48, 32'h81);
		rw(1'b1, 8'h4C, 32'h84);
		pk(1'b0, 2'd2, 1'b0, UORX_HS_STALL, 1'b0);
		pk(1'b1, 2'd0, 1'b0, UORX_HS_ACK, 1'b1);
		rchk(8'h44, 32'h89);
		rchk(8'h48, 32'h80);
		rchk(8'h4C, 32'h85);
		pk(1'b0, 2'd2, 1'b0, UORX_HS_ACK, 1'b1);
		drain();
		$display("test setup done");
		rw(1'b1, 8'h44, 32'hC8);
		for (int i = 0; i < 4; i++) pk(1'b0, 2'd1, i[0], UORX_HS_ACK, 1'b1);
		pk(1'b0, 2'd1, 1'b0, UORX_HS_NAK, 1'b0);
		chk("pkt_ready", pkt_ready, 1'b0);
		drain();
		$display("test buffer done");
		rw(1'b1, 8'h04, 32'h10);
		rw(1'b1, 8'h08, 32'h4000_0000);
		rw(1'b1, 8'h04, 32'h15);
		rw(1'b1, 8'h00, 32'h01);
		rw(1'b1, 8'h08, 32'h4000_1000);
		rnd = nxt(rnd);
		rw(1'b1, 8'h0C, rnd);
		rw(1'b1, 8'h00, 32'h31);
		chk("ctl", {mode_host, big_endian, stream_off, phy_ulpi, fs_only, port_power,
			async_run, periodic_run}, 8'b1111_0111);
		chk("async_base", async_base, rnd & 32'hFFFF_FFE0);
		rchk(8'h00, 32'h31);
		rw(1'b1, 8'h00, 32'h30);
		chk("runs", {async_run, periodic_run}, 2'b00);
		rw(1'b1, 8'h00, 32'h02);
		rchk(8'h40, 32'h80);
		rchk(8'h04, 32'h0);
		chk("off", {mode_host, port_power, phy_ulpi, async_base}, 35'h0);
		$display("test bring-up done");
		complete_run();
	end
endmodule
